// >>> core/isr_pkg.sv
// constants, commands and states of the instrument status reporting block
// assumes a single system clock; shared by the core and its bench
`default_nettype none

package isr_pkg;

  // operation condition word bit positions
  localparam int OP_CAL_BIT      = 0;
  localparam int OP_WAIT_TRG_BIT = 5;
  localparam int OP_VREG_BIT     = 8;
  localparam int OP_IREG_BIT     = 10;
  localparam int OP_LIST_BIT     = 12;

  // fault (questionable) condition word bit positions
  localparam int FT_VTRIP_BIT    = 0;
  localparam int FT_ITRIP_BIT    = 1;
  localparam int FT_HEAT_BIT     = 4;
  localparam int FT_INH_BIT      = 9;
  localparam int FT_UNREG_BIT    = 10;

  // standard event latch bit positions
  localparam int SE_OPC_BIT      = 0;
  localparam int SE_QYE_BIT      = 2;
  localparam int SE_DDE_BIT      = 3;
  localparam int SE_EXE_BIT      = 4;
  localparam int SE_CME_BIT      = 5;
  localparam int SE_PON_BIT      = 7;
  localparam logic [7:0] SE_USED_MASK = 8'hBD;

  // status byte and service request mask layout
  localparam int SB_FAULT_BIT    = 3;
  localparam int SB_MAV_BIT      = 4;
  localparam int SB_ESB_BIT      = 5;
  localparam int SB_RQS_BIT      = 6;
  localparam int SB_OPER_BIT     = 7;

  // reset values of the transition filters and masks
  localparam logic [15:0] RISE_FILTER_RST = 16'hFFFF;
  localparam logic [15:0] FALL_FILTER_RST = 16'h0000;
  localparam logic [15:0] MASK16_RST      = 16'h0000;
  localparam logic [7:0]  MASK8_RST       = 8'h00;

  // queue message byte that reports error overflow (value arbitrary)
  localparam logic [7:0] SYS_ERR_BYTE = 8'hFF;

  // commands from the message parser
  typedef enum logic [4:0] {
    ISR_CMD_NOP,
    ISR_CMD_WR_OP_RISE,
    ISR_CMD_WR_OP_FALL,
    ISR_CMD_WR_OP_MASK,
    ISR_CMD_WR_FT_RISE,
    ISR_CMD_WR_FT_FALL,
    ISR_CMD_WR_FT_MASK,
    ISR_CMD_WR_SE_MASK,
    ISR_CMD_WR_SR_MASK,
    ISR_CMD_RD_OP_COND,
    ISR_CMD_RD_OP_RISE,
    ISR_CMD_RD_OP_FALL,
    ISR_CMD_RD_OP_EVENT,
    ISR_CMD_RD_OP_MASK,
    ISR_CMD_RD_FT_COND,
    ISR_CMD_RD_FT_RISE,
    ISR_CMD_RD_FT_FALL,
    ISR_CMD_RD_FT_EVENT,
    ISR_CMD_RD_FT_MASK,
    ISR_CMD_RD_SE_EVENT,
    ISR_CMD_RD_SE_MASK,
    ISR_CMD_RD_SR_MASK,
    ISR_CMD_RD_STB,
    ISR_CMD_SERIAL_POLL,
    ISR_CMD_CLEAR,
    ISR_CMD_PRESET,
    ISR_CMD_RD_QUEUE
  } isr_cmd_t;

  // start-up sequence states
  typedef enum logic [1:0] {
    ISR_ST_WAIT_A,
    ISR_ST_WAIT_B,
    ISR_ST_LOAD,
    ISR_ST_RUN
  } isr_fsm_t;

endpackage

`default_nettype wire

// >>> core/isr_core.sv
// status reporting core: condition/filter/event groups, status byte, service request, output queue
// assumes commands from a parser on clk_in; condition pins and the power-on clear strap are asynchronous
//
// Notes on behaviour
// (RULE1) op word: calibration bit 0, waiting trigger 5
// (RULE2) op word: voltage 8, current 10, list 12
// (RULE3) fault word: overvoltage 0, overcurrent 1, thermal 4
// (RULE4) fault word: inhibit bit 9, unregulated bit 10
// (RULE5) standard events at bits 0,2,3,4,5,7
// (RULE6) status byte and request mask share layout
// (RULE7) enabled fault events OR into bit 3
// (RULE8) event read or clear command empties latch
// (RULE9) preset clears two filters; zero writes clear
// (RULE10) standard event latch read-only, cleared when read
// (RULE11) standard mask cleared at power-on if strap set
// (RULE12) standard mask gates events into bit 5
// (RULE13) poll gives request bit, query gives summary
// (RULE14) service request drives line, latches bit 6
// (RULE15) poll returns then clears request bit only
// (RULE16) master summary is live OR of enabled bits
// (RULE17) status byte query clears nothing
// (RULE18) fifo queue; message-available while nonempty
// (RULE19) queue emptied at power-on and clear command
// (RULE20) too many errors yield system error message
// (RULE21) request recurs while its cause persists
// (RULE22) condition words read-only, follow live signals
// (RULE23) event latch holds filtered changes until cleared
// (RULE24) enabled op events OR into bit 7
// (RULE25) rise with rise filter, fall with fall filter
`default_nettype none

module isr_core
  import isr_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16,
  parameter int ERR_LIMIT   = 4
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        cal_computing_in,
  input  wire logic        awaiting_trigger_in,
  input  wire logic        constant_voltage_in,
  input  wire logic        constant_current_in,
  input  wire logic        list_step_active_in,
  input  wire logic        voltage_limit_trip_in,
  input  wire logic        current_limit_trip_in,
  input  wire logic        thermal_fault_in,
  input  wire logic        remote_inhibit_active_in,
  input  wire logic        regulation_lost_in,
  input  wire logic        psc_in,
  input  wire logic [7:0]  se_mask_saved_in,
  input  wire logic [7:0]  sr_mask_saved_in,
  input  wire logic [7:0]  std_event_in,
  input  wire logic        cmd_valid_in,
  input  wire isr_cmd_t    cmd_code_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic        oq_push_in,
  input  wire logic [7:0]  oq_data_in,
  input  wire logic        oq_is_error_in,
  output logic             cmd_ready_out,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  output logic             oq_ready_out,
  output logic             srq_out
);

  localparam int AW = $clog2(QUEUE_DEPTH);
  localparam int EW = $clog2(ERR_LIMIT + 1);
  localparam logic [AW:0]   OQ_FULL  = (AW+1)'(QUEUE_DEPTH);
  localparam logic [EW-1:0] ERR_MAX  = EW'(ERR_LIMIT);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW:0]   CNT_ONE  = (AW+1)'(1);
  localparam logic [EW-1:0] ERR_ONE  = EW'(1);

  typedef struct packed {
    isr_fsm_t                     fsm;
    logic [15:0]                  op_s1, op_s2, op_prev;
    logic [15:0]                  ft_s1, ft_s2, ft_prev;
    logic [15:0]                  op_rise, op_fall, op_evt, op_mask;
    logic [15:0]                  ft_rise, ft_fall, ft_evt, ft_mask;
    logic [7:0]                   se_evt, se_mask, sr_mask;
    logic                         rqs;
    logic                         psc_s1, psc_s2;
    logic [QUEUE_DEPTH-1:0][8:0]  oq_mem;
    logic [AW-1:0]                oq_wr, oq_rd;
    logic [AW:0]                  oq_cnt;
    logic [EW-1:0]                err_cnt;
    logic                         rsp_valid;
    logic [15:0]                  rsp_data;
    logic                         cmd_ready;
    logic                         oq_ready;
  } isr_state_t;

  isr_state_t st_r;
  isr_state_t st_nxt;

  logic [15:0] op_pins;
  logic [15:0] ft_pins;
  logic [15:0] op_set;
  logic [15:0] ft_set;
  logic [7:0]  stb;
  logic        mss;
  logic        taken;
  logic        oq_empty;

  ////////////////////////////////////////////////////////////////////////////
  // condition words assembled from the monitored pins
  always_comb begin
    op_pins = '0;
    ft_pins = '0;
    op_pins[OP_CAL_BIT]      = cal_computing_in;          // [RULE1]
    op_pins[OP_WAIT_TRG_BIT] = awaiting_trigger_in;       // [RULE1]
    op_pins[OP_VREG_BIT]     = constant_voltage_in;       // [RULE2]
    op_pins[OP_IREG_BIT]     = constant_current_in;       // [RULE2]
    op_pins[OP_LIST_BIT]     = list_step_active_in;       // [RULE2]
    ft_pins[FT_VTRIP_BIT]    = voltage_limit_trip_in;     // [RULE3]
    ft_pins[FT_ITRIP_BIT]    = current_limit_trip_in;     // [RULE3]
    ft_pins[FT_HEAT_BIT]     = thermal_fault_in;          // [RULE3]
    ft_pins[FT_INH_BIT]      = remote_inhibit_active_in;  // [RULE4]
    ft_pins[FT_UNREG_BIT]    = regulation_lost_in;        // [RULE4]
  end

  ////////////////////////////////////////////////////////////////////////////
  // transition filters and summaries from registered state
  always_comb begin
    op_set = (st_r.op_s2 & ~st_r.op_prev & st_r.op_rise)
           | (~st_r.op_s2 & st_r.op_prev & st_r.op_fall);      // [RULE25]
    ft_set = (st_r.ft_s2 & ~st_r.ft_prev & st_r.ft_rise)
           | (~st_r.ft_s2 & st_r.ft_prev & st_r.ft_fall);      // [RULE25]
    if (st_r.fsm != ISR_ST_RUN) begin
      op_set = '0;
      ft_set = '0;
    end
    oq_empty = (st_r.oq_cnt == '0);
    stb = '0;
    stb[SB_FAULT_BIT] = |(st_r.ft_evt & st_r.ft_mask);          // [RULE7]
    stb[SB_MAV_BIT]   = !oq_empty;                              // [RULE18]
    stb[SB_ESB_BIT]   = |(st_r.se_evt & st_r.se_mask);          // [RULE12]
    stb[SB_OPER_BIT]  = |(st_r.op_evt & st_r.op_mask);          // [RULE24]
    stb[SB_RQS_BIT]   = st_r.rqs;                               // [RULE6]
    // request bit itself never feeds the master summary
    mss = |(stb & st_r.sr_mask & ~(8'h01 << SB_RQS_BIT));       // [RULE16]
    taken = cmd_valid_in && (st_r.fsm == ISR_ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic        rd_op;
    logic        rd_ft;
    logic        rd_se;
    logic        do_clr;
    logic        do_pop;
    logic        do_push;
    logic [8:0]  push_word;
    logic [8:0]  head;
    rd_op     = 1'b0;
    rd_ft     = 1'b0;
    rd_se     = 1'b0;
    do_clr    = 1'b0;
    do_pop    = 1'b0;
    do_push   = 1'b0;
    push_word = {oq_is_error_in, oq_data_in};
    head      = st_r.oq_mem[st_r.oq_rd];
    st_nxt    = st_r;
    st_nxt.rsp_valid = 1'b0;

    // two-flop synchronisers and edge history
    st_nxt.op_s1   = op_pins;
    st_nxt.op_s2   = st_r.op_s1;
    st_nxt.op_prev = st_r.op_s2;
    st_nxt.ft_s1   = ft_pins;
    st_nxt.ft_s2   = st_r.ft_s1;
    st_nxt.ft_prev = st_r.ft_s2;
    st_nxt.psc_s1  = psc_in;
    st_nxt.psc_s2  = st_r.psc_s1;

    // command decode
    if (taken) begin
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_data  = '0;
      case (cmd_code_in)
        ISR_CMD_WR_OP_RISE:  st_nxt.op_rise = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_OP_FALL:  st_nxt.op_fall = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_OP_MASK:  st_nxt.op_mask = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_FT_RISE:  st_nxt.ft_rise = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_FT_FALL:  st_nxt.ft_fall = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_FT_MASK:  st_nxt.ft_mask = cmd_data_in;     // [RULE9]
        ISR_CMD_WR_SE_MASK:  st_nxt.se_mask = cmd_data_in[7:0];
        ISR_CMD_WR_SR_MASK:  st_nxt.sr_mask = cmd_data_in[7:0];
        ISR_CMD_RD_OP_COND:  st_nxt.rsp_data = st_r.op_s2;     // [RULE22]
        ISR_CMD_RD_OP_RISE:  st_nxt.rsp_data = st_r.op_rise;
        ISR_CMD_RD_OP_FALL:  st_nxt.rsp_data = st_r.op_fall;
        ISR_CMD_RD_OP_MASK:  st_nxt.rsp_data = st_r.op_mask;
        ISR_CMD_RD_FT_COND:  st_nxt.rsp_data = st_r.ft_s2;     // [RULE22]
        ISR_CMD_RD_FT_RISE:  st_nxt.rsp_data = st_r.ft_rise;
        ISR_CMD_RD_FT_FALL:  st_nxt.rsp_data = st_r.ft_fall;
        ISR_CMD_RD_FT_MASK:  st_nxt.rsp_data = st_r.ft_mask;
        ISR_CMD_RD_SE_MASK:  st_nxt.rsp_data = {8'h00, st_r.se_mask};
        ISR_CMD_RD_SR_MASK:  st_nxt.rsp_data = {8'h00, st_r.sr_mask};
        ISR_CMD_RD_OP_EVENT: begin
          st_nxt.rsp_data = st_r.op_evt;
          rd_op = 1'b1;                                        // [RULE8]
        end
        ISR_CMD_RD_FT_EVENT: begin
          st_nxt.rsp_data = st_r.ft_evt;
          rd_ft = 1'b1;                                        // [RULE8]
        end
        ISR_CMD_RD_SE_EVENT: begin
          st_nxt.rsp_data = {8'h00, st_r.se_evt};
          rd_se = 1'b1;                                        // [RULE10]
        end
        ISR_CMD_RD_STB: begin
          // summary in bit 6, nothing cleared
          st_nxt.rsp_data = {8'h00, stb[7], mss, stb[5:0]};     // [RULE13] [RULE17]
        end
        ISR_CMD_SERIAL_POLL: begin
          st_nxt.rsp_data = {8'h00, stb};                       // [RULE13] [RULE15]
        end
        ISR_CMD_CLEAR: do_clr = 1'b1;                          // [RULE8] [RULE19]
        ISR_CMD_PRESET: begin
          st_nxt.op_rise = '0;                                 // [RULE9]
          st_nxt.ft_fall = '0;                                 // [RULE9]
        end
        ISR_CMD_RD_QUEUE: begin
          if (!oq_empty) begin
            st_nxt.rsp_data = {8'h00, head[7:0]};
            do_pop = 1'b1;
          end
        end
        default: st_nxt.rsp_data = '0;
      endcase
    end

    // event latches: a new event wins over a clear in the same cycle
    st_nxt.op_evt = ((rd_op || do_clr) ? '0 : st_r.op_evt) | op_set;          // [RULE23] [RULE8]
    st_nxt.ft_evt = ((rd_ft || do_clr) ? '0 : st_r.ft_evt) | ft_set;          // [RULE23] [RULE8]
    st_nxt.se_evt = ((rd_se || do_clr) ? '0 : st_r.se_evt)
                  | (std_event_in & SE_USED_MASK);                             // [RULE5]

    // request bit: latched from the live summary, cleared by the poll
    if (taken && cmd_code_in == ISR_CMD_SERIAL_POLL) begin
      st_nxt.rqs = 1'b0;                                       // [RULE15]
    end else begin
      // request withdrawn as soon as no enabled reason is left
      st_nxt.rqs = mss;                                        // [RULE14] [RULE21]
    end

    // output queue; clear drops any push in the same cycle
    if (do_clr) begin
      st_nxt.oq_wr   = '0;
      st_nxt.oq_rd   = '0;
      st_nxt.oq_cnt  = '0;                                     // [RULE19]
      st_nxt.err_cnt = '0;
    end else begin
      if (oq_push_in && (st_r.oq_cnt != OQ_FULL || do_pop) && st_r.fsm == ISR_ST_RUN) begin
        if (!oq_is_error_in) begin
          do_push = 1'b1;
        end else if (st_r.err_cnt < ERR_MAX - ERR_ONE) begin
          do_push = 1'b1;
          st_nxt.err_cnt = st_r.err_cnt + ERR_ONE;
        end else if (st_r.err_cnt == ERR_MAX - ERR_ONE) begin
          // last error slot carries the overflow message
          do_push = 1'b1;
          push_word = {1'b1, SYS_ERR_BYTE};                    // [RULE20]
          st_nxt.err_cnt = ERR_MAX;
        end
      end
      if (do_push) begin
        st_nxt.oq_mem[st_r.oq_wr] = push_word;                 // [RULE18]
        st_nxt.oq_wr = st_r.oq_wr + PTR_ONE;
      end
      if (do_pop) begin
        st_nxt.oq_rd = st_r.oq_rd + PTR_ONE;
        if (head[8] && !(do_push && oq_is_error_in)) begin
          st_nxt.err_cnt = st_nxt.err_cnt - ERR_ONE;
        end
      end
      if (do_push && !do_pop) begin
        st_nxt.oq_cnt = st_r.oq_cnt + CNT_ONE;
      end else if (do_pop && !do_push) begin
        st_nxt.oq_cnt = st_r.oq_cnt - CNT_ONE;
      end
    end

    // start-up sequence: wait for the strap synchroniser, then recall masks
    case (st_r.fsm)
      ISR_ST_WAIT_A: st_nxt.fsm = ISR_ST_WAIT_B;
      ISR_ST_WAIT_B: st_nxt.fsm = ISR_ST_LOAD;
      ISR_ST_LOAD: begin
        st_nxt.se_mask = st_r.psc_s2 ? MASK8_RST : se_mask_saved_in;   // [RULE11]
        st_nxt.sr_mask = st_r.psc_s2 ? MASK8_RST : sr_mask_saved_in;
        st_nxt.se_evt  = st_nxt.se_evt | (8'h01 << SE_PON_BIT);        // [RULE5]
        st_nxt.fsm     = ISR_ST_RUN;
      end
      ISR_ST_RUN: st_nxt.fsm = ISR_ST_RUN;
      default: st_nxt.fsm = ISR_ST_WAIT_A;
    endcase

    st_nxt.cmd_ready = (st_nxt.fsm == ISR_ST_RUN);
    st_nxt.oq_ready  = (st_nxt.fsm == ISR_ST_RUN) && (st_nxt.oq_cnt != OQ_FULL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r         <= '0;
      st_r.fsm     <= ISR_ST_WAIT_A;
      st_r.op_rise <= RISE_FILTER_RST;
      st_r.ft_rise <= RISE_FILTER_RST;
      st_r.op_fall <= FALL_FILTER_RST;
      st_r.ft_fall <= FALL_FILTER_RST;
      st_r.op_mask <= MASK16_RST;
      st_r.ft_mask <= MASK16_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign cmd_ready_out = st_r.cmd_ready;
  assign rsp_valid_out = st_r.rsp_valid;
  assign rsp_data_out  = st_r.rsp_data;
  assign oq_ready_out  = st_r.oq_ready;
  assign srq_out       = st_r.rqs;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_op_rise_latch: assert property (op_set != '0 |=> (st_r.op_evt & $past(op_set)) == $past(op_set)) // [RULE23]
    else $error("filtered operation change not latched");
  a_op_read_clear: assert property (taken && cmd_code_in == ISR_CMD_RD_OP_EVENT && op_set == '0 // [RULE8]
    |=> st_r.op_evt == '0)
    else $error("operation event not cleared by read");
  a_poll_bit_six: assert property (taken && cmd_code_in == ISR_CMD_SERIAL_POLL // [RULE15]
    |=> rsp_valid_out && rsp_data_out[SB_RQS_BIT] == $past(st_r.rqs) && !srq_out)
    else $error("serial poll did not return and clear request");
  a_mss_sets_srq: assert property (mss && !(taken && cmd_code_in == ISR_CMD_SERIAL_POLL) |=> srq_out) // [RULE14]
    else $error("service request not raised");
  a_stb_query: assert property (taken && cmd_code_in == ISR_CMD_RD_STB // [RULE13]
    |=> rsp_data_out[SB_RQS_BIT] == $past(mss) && rsp_data_out[SB_MAV_BIT] == $past(!oq_empty)
        && srq_out == $past(mss))
    else $error("status byte query wrong");
  a_fault_summary: assert property (taken && cmd_code_in == ISR_CMD_SERIAL_POLL // [RULE7]
    |=> rsp_data_out[SB_FAULT_BIT] == $past(|(st_r.ft_evt & st_r.ft_mask)))
    else $error("fault summary wrong");
  a_clear_queue: assert property (taken && cmd_code_in == ISR_CMD_CLEAR |=> st_r.oq_cnt == '0) // [RULE19]
    else $error("clear left queue data");
  a_psc_load: assert property (st_r.fsm == ISR_ST_LOAD && st_r.psc_s2 |=> st_r.se_mask == '0) // [RULE11]
    else $error("standard mask not cleared at power-on");
  a_preset_filters: assert property (taken && cmd_code_in == ISR_CMD_PRESET // [RULE9]
    |=> st_r.op_rise == '0 && st_r.ft_fall == '0)
    else $error("preset left filters set");
  a_err_bound: assert property (st_r.err_cnt <= ERR_MAX) // [RULE20]
    else $error("error count beyond limit");
  a_se_read_clear: assert property (taken && cmd_code_in == ISR_CMD_RD_SE_EVENT && std_event_in == '0 // [RULE10]
    |=> st_r.se_evt == '0)
    else $error("standard event latch not cleared by read");
  a_clear_events: assert property (taken && cmd_code_in == ISR_CMD_CLEAR && op_set == '0 && ft_set == '0 // [RULE8]
    |=> st_r.op_evt == '0 && st_r.ft_evt == '0)
    else $error("clear left group events set");
  a_srq_withdraw: assert property (!mss |=> !srq_out) // [RULE21]
    else $error("request kept without an enabled reason");
  a_full_not_ready: assert property (st_r.oq_cnt == OQ_FULL |-> !oq_ready_out) // [RULE18]
    else $error("queue full but still ready");
  a_queue_bound: assert property (st_r.oq_cnt <= OQ_FULL) // [RULE18]
    else $error("queue count beyond depth");

endmodule

`default_nettype wire

// >>> tb/isr_ctrl_model.sv
// bus controller model: issues status commands and queries on the command port
// assumes the core takes a command at a rising edge while cmd_ready is high
`default_nettype none

module isr_ctrl_model
  import isr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        cmd_ready_in,
  output var  logic        cmd_valid_out,
  output var  isr_cmd_t    cmd_code_out,
  output var  logic [15:0] cmd_data_out,
  output var  logic        hang_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle port at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = ISR_CMD_NOP;
    cmd_data_out  = 16'h0000;
    hang_out      = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one command, held across its taken edge, then released
  task automatic send(input isr_cmd_t code, input logic [15:0] data);
    int n;
    n = 0;
    @(negedge clk_in);
    while (cmd_ready_in !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 100) hang_out = 1'b1;
    cmd_code_out  = code;
    cmd_data_out  = data;
    cmd_valid_out = 1'b1;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_data_out  = ~data; // released data shows the inverse
  endtask
endmodule

`default_nettype wire

// >>> tb/test_instrument_status_reporting.sv
// bench for the status reporting core: commands, condition pins, events and queue
// assumes isr_pkg and isr_core compiled first; controller model drives commands
`default_nettype none

module test_instrument_status_reporting
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst, psc, oq_push, oq_err, cmd_valid, cmd_ready, rsp_valid, oq_ready, srq, hang;
  logic [4:0]  op_pins, ft_pins;
  logic [7:0]  se_saved, sr_saved, std_ev, oq_data, b1, b2;
  logic [15:0] cmd_data, rsp_data;
  isr_cmd_t    cmd_code;
  logic [15:0] exp_q[$];
  int          err_total, n_tests;
  localparam int OPP[5] = '{0, 5, 8, 10, 12};
  localparam int FTP[5] = '{0, 1, 4, 9, 10};

  // clock and time-zero values
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, psc, oq_push, oq_err, op_pins, ft_pins} = '0;
    {se_saved, sr_saved, std_ev, oq_data} = '0;
    err_total = 0;
    n_tests = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  isr_core #(.QUEUE_DEPTH(4), .ERR_LIMIT(2)) i_dut (
    .clk_in(clk), .sys_rst_in(rst), .cal_computing_in(op_pins[0]), .awaiting_trigger_in(op_pins[1]),
    .constant_voltage_in(op_pins[2]), .constant_current_in(op_pins[3]), .list_step_active_in(op_pins[4]),
    .voltage_limit_trip_in(ft_pins[0]), .current_limit_trip_in(ft_pins[1]), .thermal_fault_in(ft_pins[2]),
    .remote_inhibit_active_in(ft_pins[3]), .regulation_lost_in(ft_pins[4]), .psc_in(psc),
    .se_mask_saved_in(se_saved), .sr_mask_saved_in(sr_saved), .std_event_in(std_ev),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .oq_push_in(oq_push),
    .oq_data_in(oq_data), .oq_is_error_in(oq_err), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .oq_ready_out(oq_ready), .srq_out(srq));
  isr_ctrl_model i_ctrl (.clk_in(clk), .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .cmd_data_out(cmd_data), .hang_out(hang));

  //////////////////////////////////////////////////////////////////////////////
  // compare, report and close
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d of %0d comparisons", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a stuck command port ends the run
  always @(posedge hang) begin
    err_total++;
    results();
  end
  // response watcher takes the oldest note
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(rsp_data, 16'hDEAD);
      else check(rsp_data, exp_q.pop_front());
    end
  end

  // stimulus helpers
  task automatic cmd(input isr_cmd_t c, input logic [15:0] d, input logic [15:0] e);
    exp_q.push_back(e);
    i_ctrl.send(c, d);
  endtask
  task automatic do_reset(input logic p);
    @(negedge clk);
    psc = p;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic wait_srq(input logic v);
    int n;
    for (n = 0; n < 20 && srq !== v; n++) @(negedge clk);
    check({15'h0000, srq}, {15'h0000, v});
  endtask
  task automatic push(input logic [7:0] d, input logic e);
    @(negedge clk);
    {oq_push, oq_data, oq_err} = {1'b1, d, e};
    @(negedge clk);
    oq_push = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    b1 = 8'($urandom(41));
    do_reset(1'b1);
    // reset values, power-on event bit and standard mask cleared by the strap
    cmd(ISR_CMD_RD_OP_RISE, 16'h0000, RISE_FILTER_RST);
    cmd(ISR_CMD_RD_FT_FALL, 16'h0000, FALL_FILTER_RST);
    cmd(ISR_CMD_RD_FT_MASK, 16'h0000, MASK16_RST);
    cmd(ISR_CMD_RD_SE_MASK, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_SE_EVENT, 16'h0000, 16'h0080);
    cmd(ISR_CMD_RD_SE_EVENT, 16'h0000, 16'h0000);
    // each condition pin lands on its own bit
    for (int i = 0; i < 5; i++) begin
      op_pins = 5'(1 << i);
      ft_pins = 5'(1 << i);
      repeat (5) @(negedge clk);
      cmd(ISR_CMD_RD_OP_COND, 16'h0000, 16'(1) << OPP[i]);
      cmd(ISR_CMD_RD_FT_COND, 16'h0000, 16'(1) << FTP[i]);
    end
    {op_pins, ft_pins} = '0;
    repeat (5) @(negedge clk);
    cmd(ISR_CMD_RD_OP_EVENT, 16'h0000, 16'h1521);
    cmd(ISR_CMD_RD_OP_EVENT, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_FT_EVENT, 16'h0000, 16'h0613);
    cmd(ISR_CMD_RD_FT_EVENT, 16'h0000, 16'h0000);
    // fall filter only, then preset
    cmd(ISR_CMD_WR_OP_RISE, 16'h0000, 16'h0000);
    cmd(ISR_CMD_WR_OP_FALL, 16'h0400, 16'h0000);
    cmd(ISR_CMD_WR_FT_FALL, 16'h0010, 16'h0000);
    op_pins[3] = 1'b1;
    repeat (5) @(negedge clk);
    op_pins[3] = 1'b0;
    repeat (5) @(negedge clk);
    cmd(ISR_CMD_RD_OP_EVENT, 16'h0000, 16'h0400);
    cmd(ISR_CMD_WR_OP_RISE, 16'hFFFF, 16'h0000);
    cmd(ISR_CMD_PRESET, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_OP_RISE, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_FT_FALL, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_OP_FALL, 16'h0000, 16'h0400);
    // operation summary drives a service request
    cmd(ISR_CMD_WR_OP_RISE, 16'h0400, 16'h0000);
    cmd(ISR_CMD_WR_OP_MASK, 16'h0400, 16'h0000);
    cmd(ISR_CMD_WR_SR_MASK, 16'h0080, 16'h0000);
    op_pins[3] = 1'b1;
    wait_srq(1'b1);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h00C0);
    cmd(ISR_CMD_SERIAL_POLL, 16'h0000, 16'h00C0);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h00C0);
    cmd(ISR_CMD_RD_OP_EVENT, 16'h0000, 16'h0400);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0000);
    wait_srq(1'b0);
    op_pins[3] = 1'b0;
    wait_srq(1'b1);
    cmd(ISR_CMD_WR_SR_MASK, 16'h0000, 16'h0000);
    wait_srq(1'b0);
    cmd(ISR_CMD_CLEAR, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_OP_EVENT, 16'h0000, 16'h0000);
    // fault summary on bit 3
    cmd(ISR_CMD_WR_FT_MASK, 16'h0002, 16'h0000);
    cmd(ISR_CMD_WR_SR_MASK, 16'h0008, 16'h0000);
    ft_pins[1] = 1'b1;
    wait_srq(1'b1);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0048);
    cmd(ISR_CMD_RD_FT_EVENT, 16'h0000, 16'h0002);
    ft_pins[1] = 1'b0;
    repeat (5) @(negedge clk);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0000);
    // standard events through their mask into bit 5
    cmd(ISR_CMD_WR_SE_MASK, 16'h0010, 16'h0000);
    cmd(ISR_CMD_WR_SR_MASK, 16'h0020, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      b2 = (i == 0) ? 8'h10 : 8'($urandom());
      @(negedge clk);
      std_ev = b2;
      @(negedge clk);
      std_ev = 8'h00;
      repeat (3) @(negedge clk);
      cmd(ISR_CMD_RD_STB, 16'h0000, b2[4] ? 16'h0060 : 16'h0000);
      cmd(ISR_CMD_RD_SE_EVENT, 16'h0000, {8'h00, b2 & SE_USED_MASK});
    end
    cmd(ISR_CMD_WR_SR_MASK, 16'h0000, 16'h0000);
    // output queue order, message available, clear and error overflow
    push(b1, 1'b0);
    push(~b1, 1'b0);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0010);
    cmd(ISR_CMD_RD_QUEUE, 16'h0000, {8'h00, b1});
    cmd(ISR_CMD_RD_QUEUE, 16'h0000, {8'h00, ~b1});
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0000);
    for (int i = 0; i < 4; i++) push(b1, 1'b0);
    check({15'h0000, oq_ready}, 16'h0000);
    cmd(ISR_CMD_CLEAR, 16'h0000, 16'h0000);
    cmd(ISR_CMD_RD_STB, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) push(8'h20 + 8'(i), 1'b1);
    cmd(ISR_CMD_RD_QUEUE, 16'h0000, 16'h0020);
    cmd(ISR_CMD_RD_QUEUE, 16'h0000, {8'h00, SYS_ERR_BYTE});
    cmd(ISR_CMD_RD_QUEUE, 16'h0000, 16'h0000);
    // masks recalled when the strap is clear
    se_saved = 8'h3C;
    sr_saved = 8'h28;
    do_reset(1'b0);
    cmd(ISR_CMD_RD_SE_MASK, 16'h0000, 16'h003C);
    cmd(ISR_CMD_RD_SR_MASK, 16'h0000, 16'h0028);
    repeat (4) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule

`default_nettype wire
